/* File: pkg/uhsr_pkg.sv */
// Contract
// - Async schedule status bit follows the real async schedule state, may lag.
// - Periodic schedule status bit follows the real periodic schedule state.
// - Status equal to enable means transition done; mismatch means in progress.
// - Reclamation bit is read-only, reports the empty async schedule detect.
// - Halted bit resets to one and reads zero while run/stop is one.
// - After run/stop clears, finish stopping, then set halted.
// - Doorbell rung, next async advance sets the async-advance flag.
// - Serious host bus access error sets the host system error flag.
// - Host system error clears run/stop so no further descriptors run.
// - Rollover flag on index bit 13 toggle (1024), bit 12 (512) or bit 11 (256).
// - Port change flag on change or force-resume rise of non-companion port.
// - On D3-to-D0 load port change flag with OR of port change bits.
// - Transaction completing with an error sets the USB error flag.
// - Error on descriptor with interrupt-on-complete sets both flags.
// - Retiring a descriptor with interrupt-on-complete sets completion flag.
// - Short packet detection also sets the completion flag.
// - Interrupt raised when a flag and its enable are both set.
package uhsr_pkg;

  localparam logic [7:0] HOST_STATUS_OFFSET = 8'h24;

  // Bit positions inside the status word
  localparam int ASYNC_STAT_BIT = 15;
  localparam int PER_STAT_BIT = 14;
  localparam int RECLAMATION_FLAG_BIT = 13;
  localparam int HALTED_BIT = 12;
  localparam int ADVANCE_BIT = 5;
  localparam int SYS_ERR_BIT = 4;
  localparam int ROLLOVER_BIT = 3;
  localparam int PORT_CHG_BIT = 2;
  localparam int USB_ERR_BIT = 1;
  localparam int COMPLETE_BIT = 0;
  localparam int NUM_FLAGS = 6;

  // Frame index bits watched per list size
  localparam int IDX_BIT_1024 = 13;
  localparam int IDX_BIT_512 = 12;
  localparam int IDX_BIT_256 = 11;
  localparam int FRAME_INDEX_W = 14;

  localparam logic [1:0] FLS_1024 = 2'h0;
  localparam logic [1:0] FLS_512 = 2'h1;
  localparam logic [1:0] FLS_256 = 2'h2;

  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    UHSR_RUN = 3'b001,
    UHSR_STOPPING = 3'b010,
    UHSR_HALTED = 3'b100
  } uhsr_state_t;

endpackage

/* File: rtl/uhsr_status.sv */
`timescale 1ns/1ps
module uhsr_status #(
  parameter int NUM_PORTS = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port at the status offset
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Command register bits
  input wire logic run_stop,
  input wire logic async_sched_enable,
  input wire logic periodic_sched_enable,
  input wire logic async_advance_doorbell,
  input wire logic [1:0] frame_list_size,
  input wire logic [5:0] irq_enable_reg,
  // Schedule engine
  input wire logic async_running,
  input wire logic periodic_running,
  input wire logic reclamation_in,
  input wire logic engine_idle,
  input wire logic async_advanced,
  input wire logic td_retire,
  input wire logic td_error,
  input wire logic td_ioc,
  input wire logic short_packet,
  // Host bus master
  input wire logic host_bus_error,
  // Frame index counter
  input wire logic [13:0] frame_index,
  // Port logic
  input wire logic [NUM_PORTS-1:0] port_change_bits,
  input wire logic [NUM_PORTS-1:0] companion_owns_port,
  input wire logic [NUM_PORTS-1:0] force_port_resume,
  input wire logic [NUM_PORTS-1:0] port_suspended,
  input wire logic power_d3_to_d0,
  // Results
  output logic irq_out,
  output logic run_stop_clear,
  output logic halted_out,
  output logic async_settled,
  output logic periodic_settled
);

  typedef struct packed {
    uhsr_pkg::uhsr_state_t state;
    logic async_stat;
    logic per_stat;
    logic reclamation_flag;
    logic [5:0] flags;
    logic db_pending;
    logic [2:0] fi_prev;
    logic [NUM_PORTS-1:0] chg_prev;
    logic [NUM_PORTS-1:0] fpr_prev;
    logic [31:0] rdata;
    logic irq;
    logic rs_clear;
    logic async_ok;
    logic per_ok;
  } uhsr_regs_t;

  uhsr_regs_t q;
  uhsr_regs_t d;

  ////////////////////////////////////////////////////////////////////////
  // Event decode

  logic reg_hit;
  logic wr_hit;
  logic rd_hit;
  logic idx_toggle;
  logic rollover_evt;
  logic port_evt;
  logic power_load;
  logic advance_evt;
  logic complete_evt;
  logic usb_err_evt;
  logic halted_view;
  logic [5:0] set_vec;
  logic [5:0] clr_vec;
  logic [31:0] status_word;

  assign reg_hit = (reg_addr == uhsr_pkg::HOST_STATUS_OFFSET);
  assign wr_hit = reg_wr_en & reg_hit;
  assign rd_hit = reg_rd_en & reg_hit;

  // Size code 3 is reserved, so no rollover is reported for it
  always_comb begin
    case (frame_list_size)
      uhsr_pkg::FLS_1024: begin
        idx_toggle = frame_index[uhsr_pkg::IDX_BIT_1024] != q.fi_prev[2];
      end
      uhsr_pkg::FLS_512: begin
        idx_toggle = frame_index[uhsr_pkg::IDX_BIT_512] != q.fi_prev[1];
      end
      uhsr_pkg::FLS_256: begin
        idx_toggle = frame_index[uhsr_pkg::IDX_BIT_256] != q.fi_prev[0];
      end
      default: begin
        idx_toggle = 1'b0;
      end
    endcase
  end
  assign rollover_evt = idx_toggle;

  // Companion-owned ports report only through the D3-to-D0 load below
  assign port_evt = |(~companion_owns_port &
    ((port_change_bits & ~q.chg_prev) |
     (force_port_resume & ~q.fpr_prev & port_suspended)));
  assign power_load = power_d3_to_d0 & (|port_change_bits);

  // Doorbell rung in the same cycle as an advance waits for the next one
  assign advance_evt = q.db_pending & async_advanced;
  assign usb_err_evt = td_error;
  assign complete_evt = (td_retire & td_ioc) | (td_error & td_ioc) |
    short_packet;

  always_comb begin
    set_vec = 6'h00;
    set_vec[uhsr_pkg::ADVANCE_BIT] = advance_evt;
    set_vec[uhsr_pkg::SYS_ERR_BIT] = host_bus_error;
    set_vec[uhsr_pkg::ROLLOVER_BIT] = rollover_evt;
    set_vec[uhsr_pkg::PORT_CHG_BIT] = port_evt | power_load;
    set_vec[uhsr_pkg::USB_ERR_BIT] = usb_err_evt;
    set_vec[uhsr_pkg::COMPLETE_BIT] = complete_evt;
  end

  // Only the flag bits respond to writes; reserved bits are dropped
  assign clr_vec = wr_hit ? reg_wdata[5:0] : 6'h00;

  // Halted masked by run/stop so it never reads one while running
  assign halted_view = (q.state == uhsr_pkg::UHSR_HALTED) & ~run_stop;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[uhsr_pkg::ASYNC_STAT_BIT] = q.async_stat;
    status_word[uhsr_pkg::PER_STAT_BIT] = q.per_stat;
    status_word[uhsr_pkg::RECLAMATION_FLAG_BIT] = q.reclamation_flag;
    status_word[uhsr_pkg::HALTED_BIT] = halted_view;
    status_word[5:0] = q.flags;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.async_stat = async_running;
    d.per_stat = periodic_running;
    d.reclamation_flag = reclamation_in;
    d.async_ok = async_running == async_sched_enable;
    d.per_ok = periodic_running == periodic_sched_enable;
    // Set wins over a write-one clear in the same cycle
    d.flags = (q.flags & ~clr_vec) | set_vec;
    if (async_advance_doorbell) begin
      d.db_pending = 1'b1;
    end else if (advance_evt) begin
      d.db_pending = 1'b0;
    end
    d.fi_prev = frame_index[uhsr_pkg::IDX_BIT_1024:uhsr_pkg::IDX_BIT_256];
    d.chg_prev = port_change_bits;
    d.fpr_prev = force_port_resume;
    d.rs_clear = host_bus_error;
    d.irq = |(q.flags & irq_enable_reg);
    if (reg_rd_en) begin
      d.rdata = rd_hit ? status_word : 32'h0000_0000;
    end
    case (q.state)
      uhsr_pkg::UHSR_RUN: begin
        // A bus error stops execution even before run/stop drops
        if (!run_stop || host_bus_error) begin
          d.state = uhsr_pkg::UHSR_STOPPING;
        end
      end
      uhsr_pkg::UHSR_STOPPING: begin
        if (run_stop && !host_bus_error) begin
          d.state = uhsr_pkg::UHSR_RUN;
        end else if (engine_idle) begin
          d.state = uhsr_pkg::UHSR_HALTED;
        end
      end
      uhsr_pkg::UHSR_HALTED: begin
        if (run_stop) begin
          d.state = uhsr_pkg::UHSR_RUN;
        end
      end
      default: begin
        d.state = uhsr_pkg::UHSR_HALTED;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.state <= uhsr_pkg::UHSR_HALTED;
      q.flags <= uhsr_pkg::FLAGS_RESET;
      q.rdata <= uhsr_pkg::RDATA_RESET;
      q.async_ok <= 1'b1;
      q.per_ok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq_out = q.irq;
  assign run_stop_clear = q.rs_clear;
  assign halted_out = q.state == uhsr_pkg::UHSR_HALTED;
  assign async_settled = q.async_ok;
  assign periodic_settled = q.per_ok;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_stop_seen;
    !run_stop && engine_idle && !host_bus_error;
  endsequence

  sequence s_doorbell_then_advance;
    async_advance_doorbell ##1 (async_advanced && !async_advance_doorbell);
  endsequence

  chk_async_status: assert property (
    $rose(async_running) |=> q.async_stat ##1 (q.async_stat || !async_running))
    else $error("async schedule status missed the running edge");

  chk_periodic_status: assert property (
    $fell(periodic_running) |=> !q.per_stat)
    else $error("periodic schedule status stayed set");

  chk_sched_settle: assert property (
    (async_running == async_sched_enable)[*2] |-> async_settled)
    else $error("async settled not shown after match");

  chk_reclamation_flag_readonly: assert property (
    wr_hit && reg_wdata[uhsr_pkg::RECLAMATION_FLAG_BIT] && !reclamation_in |=> !q.reclamation_flag)
    else $error("reclamation bit took a write");

  chk_halted_run: assert property (
    run_stop |=> !halted_out)
    else $error("halted shown while run/stop set");

  chk_halt_after_stop: assert property (
    s_stop_seen ##1 s_stop_seen |=> halted_out)
    else $error("halted not set after stopping");

  chk_doorbell_flag: assert property (
    s_doorbell_then_advance |=> q.flags[uhsr_pkg::ADVANCE_BIT])
    else $error("async advance flag not set after doorbell");

  chk_sys_error: assert property (
    host_bus_error |=> q.flags[uhsr_pkg::SYS_ERR_BIT] && run_stop_clear)
    else $error("system error flag or run/stop clear missing");

  chk_rs_clear_only: assert property (
    run_stop_clear |-> $past(host_bus_error))
    else $error("run/stop clear without a bus error");

  chk_rollover_1024: assert property (
    frame_list_size == uhsr_pkg::FLS_1024 &&
    frame_index[uhsr_pkg::IDX_BIT_1024] != q.fi_prev[2]
    |=> q.flags[uhsr_pkg::ROLLOVER_BIT])
    else $error("rollover flag missed for 1024 entries");

  chk_rollover_256: assert property (
    frame_list_size == uhsr_pkg::FLS_256 &&
    frame_index[uhsr_pkg::IDX_BIT_256] != q.fi_prev[0]
    |=> q.flags[uhsr_pkg::ROLLOVER_BIT])
    else $error("rollover flag missed for 256 entries");

  chk_port_change: assert property (
    port_evt |=> q.flags[uhsr_pkg::PORT_CHG_BIT])
    else $error("port change flag missed");

  chk_power_load: assert property (
    power_d3_to_d0 && |port_change_bits |=> q.flags[uhsr_pkg::PORT_CHG_BIT])
    else $error("port change flag not loaded on power resume");

  chk_err_ioc: assert property (
    td_error && td_ioc |=> q.flags[uhsr_pkg::USB_ERR_BIT] &&
    q.flags[uhsr_pkg::COMPLETE_BIT])
    else $error("error with completion did not set both flags");

  chk_usb_error: assert property (
    td_error |=> q.flags[uhsr_pkg::USB_ERR_BIT])
    else $error("usb error flag missed");

  chk_retire_ioc: assert property (
    td_retire && td_ioc |=> q.flags[uhsr_pkg::COMPLETE_BIT])
    else $error("completion flag missed on retire");

  chk_short_packet: assert property (
    short_packet |=> q.flags[uhsr_pkg::COMPLETE_BIT])
    else $error("completion flag missed on short packet");

  chk_w1c_clear: assert property (
    wr_hit && reg_wdata[uhsr_pkg::ROLLOVER_BIT] && !rollover_evt
    |=> !q.flags[uhsr_pkg::ROLLOVER_BIT])
    else $error("rollover flag not cleared by write one");

  chk_w0_keep: assert property (
    wr_hit && !reg_wdata[uhsr_pkg::USB_ERR_BIT] &&
    q.flags[uhsr_pkg::USB_ERR_BIT] |=> q.flags[uhsr_pkg::USB_ERR_BIT])
    else $error("usb error flag lost on write zero");

  chk_irq_gate: assert property (
    |(q.flags & irq_enable_reg) |=> irq_out)
    else $error("interrupt not raised for enabled flag");

  chk_irq_quiet: assert property (
    !(|(q.flags & irq_enable_reg)) |=> !irq_out)
    else $error("interrupt raised without enabled flag");

  chk_read_word: assert property (
    rd_hit |=> reg_rdata[uhsr_pkg::HALTED_BIT] == $past(halted_view))
    else $error("halted bit read back wrong");

  chk_halted_read: assert property (
    rd_hit && run_stop |=> !reg_rdata[uhsr_pkg::HALTED_BIT])
    else $error("halted bit read as one while run/stop set");

  chk_rollover_512: assert property (
    frame_list_size == uhsr_pkg::FLS_512 &&
    frame_index[uhsr_pkg::IDX_BIT_512] != q.fi_prev[1]
    |=> q.flags[uhsr_pkg::ROLLOVER_BIT])
    else $error("rollover flag missed for 512 entries");

  chk_advance_wait: assert property (
    async_advanced && !q.db_pending && !q.flags[uhsr_pkg::ADVANCE_BIT]
    |=> !q.flags[uhsr_pkg::ADVANCE_BIT])
    else $error("async advance flag set without a doorbell");

  chk_reserved_read: assert property (
    rd_hit |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[11:6] == 6'h00)
    else $error("reserved status bits read as nonzero");

endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic run_stop = 1'b0, async_sched_enable = 1'b0;
  logic periodic_sched_enable = 1'b0, async_advance_doorbell = 1'b0;
  logic [1:0] frame_list_size = 2'h0;
  logic [5:0] irq_enable_reg = 6'h00;
  logic async_running = 1'b0, periodic_running = 1'b0;
  logic reclamation_in = 1'b0, engine_idle = 1'b1;
  logic async_advanced = 1'b0, td_retire = 1'b0, td_error = 1'b0;
  logic td_ioc = 1'b0, short_packet = 1'b0, host_bus_error = 1'b0;
  logic [13:0] frame_index = 14'h0000;
  logic [1:0] port_change_bits = 2'h0, companion_owns_port = 2'h0;
  logic [1:0] force_port_resume = 2'h0, port_suspended = 2'h0;
  logic power_d3_to_d0 = 1'b0;
  logic [31:0] reg_rdata;
  logic irq_out, run_stop_clear, halted_out, async_settled;
  logic periodic_settled;
  int errors = 0;
  int cmp_count = 0;

  // Row: event code above, expected event flags below
  localparam logic [10:0] row_tab [17] = '{
    {5'd0, 6'h01},
    {5'd1, 6'h00},
    {5'd2, 6'h02},
    {5'd3, 6'h03},
    {5'd4, 6'h01},
    {5'd5, 6'h10},
    {5'd6, 6'h08},
    {5'd7, 6'h08},
    {5'd8, 6'h08},
    {5'd9, 6'h00},
    {5'd10, 6'h00},
    {5'd11, 6'h04},
    {5'd12, 6'h00},
    {5'd13, 6'h04},
    {5'd14, 6'h00},
    {5'd15, 6'h20},
    {5'd16, 6'h04}
  };

  uhsr_status #(.NUM_PORTS(2)) u_dut (
    .mclk, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata, .run_stop, .async_sched_enable, .periodic_sched_enable,
    .async_advance_doorbell, .frame_list_size, .irq_enable_reg,
    .async_running, .periodic_running, .reclamation_in, .engine_idle,
    .async_advanced, .td_retire, .td_error, .td_ioc, .short_packet,
    .host_bus_error, .frame_index, .port_change_bits, .companion_owns_port,
    .force_port_resume, .port_suspended, .power_d3_to_d0, .irq_out,
    .run_stop_clear, .halted_out, .async_settled, .periodic_settled
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge mclk);
    reg_rd_en = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge mclk);
    reg_wr_en = 1'b0;
  endtask

  task automatic run_row(input logic [4:0] c);
    frame_list_size = (c >= 5'd7 && c <= 5'd9) ? 2'(c - 5'd6) : 2'h0;
    if (c == 5'd12 || c == 5'd16) companion_owns_port = 2'b10;
    if (c == 5'd16) port_change_bits = 2'b10;
    if (c == 5'd13) port_suspended = 2'b01;
    cyc(2);
    // Clear only after setup so a size switch cannot leak into the row
    wr(8'h24, 32'h0000_003f);
    case (c)
      5'd0: begin td_retire = 1'b1; td_ioc = 1'b1; end
      5'd1: td_retire = 1'b1;
      5'd2: td_error = 1'b1;
      5'd3: begin td_error = 1'b1; td_ioc = 1'b1; end
      5'd4: short_packet = 1'b1;
      5'd5: host_bus_error = 1'b1;
      5'd6, 5'd9: frame_index ^= 14'h2000;
      5'd7, 5'd10: frame_index ^= 14'h1000;
      5'd8: frame_index ^= 14'h0800;
      5'd11: port_change_bits = 2'b01;
      5'd12: port_change_bits = 2'b10;
      5'd13: force_port_resume = 2'b01;
      5'd14: async_advanced = 1'b1;
      5'd15: begin
        async_advance_doorbell = 1'b1;
        cyc(1);
        async_advance_doorbell = 1'b0;
        async_advanced = 1'b1;
      end
      default: power_d3_to_d0 = 1'b1;
    endcase
    cyc(1);
    {td_retire, td_error, td_ioc, short_packet} = 4'h0;
    {host_bus_error, async_advanced, power_d3_to_d0} = 3'h0;
    cyc(1);
    rd(8'h24);
    {port_change_bits, force_port_resume} = 4'h0;
    {port_suspended, companion_owns_port} = 4'h0;
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    errors++;
    print_verdict();
  end

  initial begin
    cyc(20);
    sys_rst = 1'b0;
    chk1(halted_out, 1'b1);
    chk1(irq_out, 1'b0);
    chk1(run_stop_clear, 1'b0);
    chk1(async_settled & periodic_settled, 1'b1);
    rd(8'h24);
    chk32(reg_rdata, 32'h0000_1000);
    // Interrupts stay disabled so the table also shows polling
    for (int i = 0; i < 17; i++) begin
      run_row(row_tab[i][10:6]);
      chk32({26'h0, reg_rdata[5:0]}, {26'h0, row_tab[i][5:0]});
    end
    chk1(irq_out, 1'b0);
    wr(8'h24, 32'h0000_003f);
    rd(8'h24);
    chk32(reg_rdata, 32'h0000_1000);
    rd(8'h20);
    chk32(reg_rdata, 32'h0000_0000);
    irq_enable_reg = 6'h02;
    run_row(5'd2);
    chk1(irq_out, 1'b1);
    wr(8'h20, 32'h0000_003f);
    wr(8'h24, 32'h0000_f000);
    rd(8'h24);
    chk32(reg_rdata, 32'h0000_1002);
    irq_enable_reg = 6'h01;
    cyc(2);
    chk1(irq_out, 1'b0);
    irq_enable_reg = 6'h02;
    wr(8'h24, 32'h0000_0002);
    cyc(1);
    chk1(irq_out, 1'b0);
    async_sched_enable = 1'b1;
    cyc(2);
    chk1(async_settled, 1'b0);
    async_running = 1'b1;
    reclamation_in = 1'b1;
    cyc(3);
    chk1(async_settled, 1'b1);
    periodic_sched_enable = 1'b1;
    cyc(2);
    chk1(periodic_settled, 1'b0);
    periodic_running = 1'b1;
    cyc(3);
    chk1(periodic_settled, 1'b1);
    wr(8'h24, 32'h0000_f000);
    rd(8'h24);
    chk32(reg_rdata, 32'h0000_f000);
    // Engine busy while running, so the stop has to wait for idle
    run_stop = 1'b1;
    engine_idle = 1'b0;
    cyc(2);
    chk1(halted_out, 1'b0);
    rd(8'h24);
    chk32(reg_rdata, 32'h0000_e000);
    host_bus_error = 1'b1;
    cyc(1);
    host_bus_error = 1'b0;
    chk1(run_stop_clear, 1'b1);
    cyc(1);
    chk1(run_stop_clear, 1'b0);
    run_stop = 1'b0;
    cyc(4);
    chk1(halted_out, 1'b0);
    engine_idle = 1'b1;
    cyc(2);
    chk1(halted_out, 1'b1);
    rd(8'h24);
    chk32(reg_rdata, 32'h0000_f010);
    print_verdict();
  end
endmodule
